// >>> pkg/gpmp_defines.vh
/*
 Constants for the 8-bit port with per-pin control and shared config mask.
 Assumes inclusion by bare name from design files.
*/
`ifndef GPMP_DEFINES_VH
`define GPMP_DEFINES_VH

`define GPMP_OFF_DIR       12'h000
`define GPMP_OFF_OUT       12'h004
`define GPMP_OFF_DRIVE_SET_STROBE    12'h008
`define GPMP_OFF_DRIVE_CLEAR_STROBE    12'h00C
`define GPMP_OFF_DRIVE_FLIP_STROBE    12'h010
`define GPMP_OFF_IN        12'h014
`define GPMP_OFF_MASK      12'h018
`define GPMP_OFF_PIN0      12'h040
`define GPMP_PIN_STRIDE    12'h004
`define GPMP_PIN_SEL_HI    4
`define GPMP_PIN_SEL_LO    2
`define GPMP_PIN_BASE_HI   11
`define GPMP_PIN_BASE_LO   5
`define GPMP_PIN_BASE_VAL  7'h02

`define GPMP_OPC_LSB       3
`define GPMP_OPC_MSB       5
`define GPMP_OPC_TOTEM     3'h0
`define GPMP_OPC_PULLUP    3'h3
`define GPMP_OPC_WAND      3'h5
`define GPMP_OPC_WANDPULL  3'h7

`define GPMP_RST_BYTE      8'h00
`define GPMP_RST_WORD      32'h0000_0000

`endif

// >>> hw/gpmp_sync.v
/*
 Two-flop synchroniser for the pin input levels.
 Assumes pclk domain; async active-low reset.
*/
`timescale 1ns/1ps
`include "gpmp_defines.vh"

module gpmp_sync #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // Data
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= {WIDTH{1'b0}};
         q        <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// >>> hw/gpmp_pinbank.v
/*
 Bank of per-pin control registers with multi-pin write.
 Assumes the caller gives a one-cycle write strobe and a select mask.
*/
`timescale 1ns/1ps
`include "gpmp_defines.vh"

module gpmp_pinbank #(
   parameter PINS = 8
) (
   // Clock and reset
   input  wire            pclk,
   input  wire            presetn,
   // Write side
   input  wire            wr_en,
   input  wire [PINS-1:0] wr_sel,
   input  wire [7:0]      wr_data,
   // Read side
   input  wire [2:0]      rd_idx,
   output reg  [7:0]      rd_data,
   // Config fields per pin
   output wire [3*PINS-1:0] opc_flat
);

   reg [7:0] ctrl_reg [0:PINS-1];

   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : pin
         // Each pin owns its control byte
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_reg[g] <= `GPMP_RST_BYTE;
            end else if (wr_en && wr_sel[g]) begin
               ctrl_reg[g] <= wr_data;
            end
         end
         assign opc_flat[3*g+2:3*g] = ctrl_reg[g][`GPMP_OPC_MSB:`GPMP_OPC_LSB];
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= `GPMP_RST_BYTE;
      end else begin
         rd_data <= ctrl_reg[rd_idx];
      end
   end

endmodule

// >>> hw/gpmp_port.v
/*
 8-bit general-purpose port: direction, output value with set, clear and
 flip strobes, per-pin control bytes, shared multi-pin config mask, and
 pin drivers with wired-AND and pull-up support. APB slave, zero waits
 on writes, one wait state on reads.
 Assumes pins are synchronous-safe after the two-flop stage, and that
 the pad pulls up when pull_en is high.
*/
`timescale 1ns/1ps
`include "gpmp_defines.vh"

module gpmp_port #(
   parameter PINS = 8
) (
   // Clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // APB slave
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [11:0]      paddr,
   input  wire [31:0]      pwdata,
   output wire             pready,
   output reg  [31:0]      prdata,
   output wire             pslverr,
   // Shared mask, from or to the global settings block
   input  wire             mask_ext_wr,
   input  wire [PINS-1:0]  mask_ext_data,
   output wire [PINS-1:0]  multi_pin_config_mask,
   // Pins
   input  wire [PINS-1:0]  pin_in,
   output reg  [PINS-1:0]  pin_out,
   output reg  [PINS-1:0]  pin_oe_n,
   output reg  [PINS-1:0]  pull_en
);

   reg  [PINS-1:0] dir_reg;
   reg  [PINS-1:0] out_reg;
   reg  [PINS-1:0] out_next;
   reg  [PINS-1:0] mask_reg;
   reg  [PINS-1:0] mask_next;
   reg             rd_wait_reg;
   wire [PINS-1:0] in_sync;
   wire [3*PINS-1:0] opc_flat;
   wire [7:0]      ctrl_rd;
   wire            setup;
   wire            wr;
   wire            rd_acc;
   wire            pin_hit;
   wire            known;
   wire [2:0]      pin_idx;
   wire [PINS-1:0] wr_byte;
   wire [PINS-1:0] pin_sel;

   // Control-byte window decode, used by read and write paths
   function is_pin_addr;
      input [11:0] a;
      begin
         is_pin_addr = (a[`GPMP_PIN_BASE_HI:`GPMP_PIN_BASE_LO] == `GPMP_PIN_BASE_VAL)
                       && (a[`GPMP_PIN_SEL_LO-1:0] == 2'b00);
      end
   endfunction

   function is_known;
      input [11:0] a;
      begin
         is_known = is_pin_addr(a) || (a == `GPMP_OFF_DIR) || (a == `GPMP_OFF_OUT)
                    || (a == `GPMP_OFF_DRIVE_SET_STROBE) || (a == `GPMP_OFF_DRIVE_CLEAR_STROBE)
                    || (a == `GPMP_OFF_DRIVE_FLIP_STROBE) || (a == `GPMP_OFF_IN)
                    || (a == `GPMP_OFF_MASK);
      end
   endfunction

   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign pin_hit = is_pin_addr(paddr);
   assign known   = is_known(paddr);
   assign pin_idx = paddr[`GPMP_PIN_SEL_HI:`GPMP_PIN_SEL_LO];
   assign wr_byte = pwdata[PINS-1:0];
   // Reads wait one cycle so control-byte data come out of a register
   assign pready  = pwrite ? 1'b1 : rd_wait_reg;
   assign pslverr = psel & penable & pready & ~known;

   // Empty mask means the single addressed pin only
   assign pin_sel = (mask_reg != {PINS{1'b0}}) ? mask_reg
                                               : ({{(PINS-1){1'b0}}, 1'b1} << pin_idx);

   gpmp_sync #(
      .WIDTH (PINS)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pin_in),
      .q       (in_sync)
   );

   gpmp_pinbank #(
      .PINS (PINS)
   ) u_bank (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_en    (wr & pin_hit),
      .wr_sel   (pin_sel),
      .wr_data  (pwdata[7:0]),
      .rd_idx   (pin_idx),
      .rd_data  (ctrl_rd),
      .opc_flat (opc_flat)
   );

   always @* begin
      out_next = out_reg;
      if (wr) begin
         case (paddr)
            `GPMP_OFF_OUT:    out_next = wr_byte;
            `GPMP_OFF_DRIVE_SET_STROBE: out_next = out_reg | wr_byte;
            `GPMP_OFF_DRIVE_CLEAR_STROBE: out_next = out_reg & ~wr_byte;
            `GPMP_OFF_DRIVE_FLIP_STROBE: out_next = out_reg ^ wr_byte;
            default:          out_next = out_reg;
         endcase
      end
   end

   // Mask is a single register; another port in the system writes it via mask_ext_*
   always @* begin
      mask_next = mask_reg;
      if (wr && pin_hit) begin
         mask_next = {PINS{1'b0}};
      end
      if (wr && (paddr == `GPMP_OFF_MASK)) begin
         mask_next = wr_byte;
      end else if (mask_ext_wr) begin
         mask_next = mask_ext_data;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_reg     <= {PINS{1'b0}};
         out_reg     <= {PINS{1'b0}};
         mask_reg    <= {PINS{1'b0}};
         rd_wait_reg <= 1'b0;
      end else begin
         out_reg     <= out_next;
         mask_reg    <= mask_next;
         rd_wait_reg <= rd_acc & ~rd_wait_reg;
         if (wr && (paddr == `GPMP_OFF_DIR)) begin
            dir_reg <= wr_byte;
         end
      end
   end

   assign multi_pin_config_mask = mask_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `GPMP_RST_WORD;
      end else if (setup && !pwrite) begin
         prdata <= `GPMP_RST_WORD;
         case (paddr)
            `GPMP_OFF_DIR:  prdata[PINS-1:0] <= dir_reg;
            `GPMP_OFF_OUT:  prdata[PINS-1:0] <= out_reg;
            `GPMP_OFF_IN:   prdata[PINS-1:0] <= in_sync;
            `GPMP_OFF_MASK: prdata[PINS-1:0] <= mask_reg;
            default:        prdata <= `GPMP_RST_WORD;
         endcase
      end else if (rd_acc && !rd_wait_reg && pin_hit) begin
         prdata <= {24'h00_0000, ctrl_rd};
      end
   end

   // Pad drive per pin; registered so outputs come from flip-flops
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out  <= {PINS{1'b0}};
         pin_oe_n <= {PINS{1'b1}};
         pull_en  <= {PINS{1'b0}};
      end else begin
         for (i = 0; i < PINS; i = i + 1) begin
            pin_out[i]  <= out_next[i];
            pull_en[i]  <= 1'b0;
            pin_oe_n[i] <= ~dir_reg[i];
            case (opc_flat[3*i+:3])
               `GPMP_OPC_WAND, `GPMP_OPC_WANDPULL: begin
                  pin_out[i]  <= 1'b0;
                  pin_oe_n[i] <= ~(dir_reg[i] & ~out_next[i]);
                  pull_en[i]  <= (opc_flat[3*i+:3] == `GPMP_OPC_WANDPULL);
               end
               `GPMP_OPC_PULLUP: begin
                  pull_en[i] <= ~dir_reg[i];
               end
               default: begin
                  pull_en[i] <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// >>> sim/gpmp_pad.sv
/*
 Board model at the pins: a wired-AND peer that may pull low, floating lines.
 Assumes the port's pin outputs settle on pclk.
*/
`timescale 1ns/1ps
module gpmp_pad (
   // Clock
   input  wire       pclk,
   // From the port
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe_n,
   input  wire [7:0] pull_en,
   // Peer driver, one pulls low
   input  wire [7:0] peer_low,
   // Back to the port
   output wire [7:0] pin_in
);
   reg [7:0] flt_reg = 8'h00;
   // Unpulled released line wanders, so no stale level is read back
   always @(posedge pclk) flt_reg <= ~flt_reg;
   assign pin_in = ~peer_low & ((~pin_oe_n & pin_out) | (pin_oe_n & (pull_en | flt_reg)));
endmodule

// >>> sim/gpmp_port_props.sv
/*
 Port checker: APB timing, shared mask load and self-clear, input reads.
 Assumes binding to gpmp_port; single pclk domain.
*/
`timescale 1ns/1ps
`include "gpmp_defines.vh"
module gpmp_port_props #(
   parameter PINS = 8
) (
   input wire            pclk,
   input wire            presetn,
   input wire            psel,
   input wire            penable,
   input wire            pwrite,
   input wire [11:0]     paddr,
   input wire [31:0]     pwdata,
   input wire            pready,
   input wire [31:0]     prdata,
   input wire            pslverr,
   input wire            mask_ext_wr,
   input wire [PINS-1:0] mask_ext_data,
   input wire [PINS-1:0] multi_pin_config_mask,
   input wire [PINS-1:0] pin_in
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire            acc = psel & penable & pready;
   wire            wr  = acc & pwrite;
   wire            ctl = paddr[11:5] == `GPMP_PIN_BASE_VAL;
   wire            unm = (paddr[1:0] == 2'b00) & (paddr > 12'h018)
                         & ((paddr < 12'h040) | (paddr > 12'h05C));
   reg  [PINS-1:0] prev_reg;
   reg  [3:0]      stab_reg;
   // Count quiet cycles so synchroniser delay cannot skew the compare
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= {PINS{1'b0}};
         stab_reg <= 4'h0;
      end else begin
         prev_reg <= pin_in;
         if (pin_in != prev_reg) begin
            stab_reg <= 4'h0;
         end else if (stab_reg != 4'hf) begin
            stab_reg <= stab_reg + 4'h1;
         end
      end
   end
   sequence rd_setup;
      psel & !penable & !pwrite;
   endsequence
   sequence rd_wait;
      !pready ##1 pready;
   endsequence
   AST_RD_WAIT: assert property (rd_setup |=> rd_wait)
      else $error("read wait wrong");
   AST_WR_ZW: assert property (psel & !penable & pwrite |=> pready)
      else $error("write waited");
   AST_MASK_CLR: assert property (wr & ctl & (|multi_pin_config_mask) & !mask_ext_wr
      |=> multi_pin_config_mask == 0) else $error("mask kept");
   AST_MASK_LD: assert property (wr & (paddr == `GPMP_OFF_MASK)
      |=> multi_pin_config_mask == $past(pwdata[PINS-1:0])) else $error("mask load");
   AST_EXT_LD: assert property (mask_ext_wr & !wr
      |=> multi_pin_config_mask == $past(mask_ext_data)) else $error("ext mask load");
   AST_MASK_HOLD: assert property (!mask_ext_wr & !wr
      |=> $stable(multi_pin_config_mask)) else $error("mask moved");
   AST_IN_RD: assert property (acc & !pwrite & (paddr == `GPMP_OFF_IN)
      & (stab_reg > 4'h7) |-> prdata[PINS-1:0] == pin_in) else $error("input read");
   AST_UNMAP: assert property (acc & unm |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access");
endmodule
bind gpmp_port gpmp_port_props #(.PINS(PINS)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .mask_ext_wr(mask_ext_wr), .mask_ext_data(mask_ext_data),
   .multi_pin_config_mask(multi_pin_config_mask), .pin_in(pin_in));

// >>> sim/gpmp_port_tb.sv
/*
 Self-checking bench for gpmp_port: APB master, output ops, multi-pin writes.
 Assumes gpmp_pad as board model and gpmp_defines.vh offsets.
*/
`timescale 1ns/1ps
`include "gpmp_defines.vh"
module gpmp_port_tb;
   reg         pclk, presetn, psel, penable, pwrite, mask_ext_wr, se;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   reg  [7:0]  mask_ext_data, peer_low, dir, ov, q, m, e, d;
   reg  [7:0]  ctl [0:7];
   reg  [2:0]  i;
   reg  [1:0]  op;
   wire        pready, pslverr;
   wire [31:0] prdata;
   wire [7:0]  mpcm, pin_in, pin_out, pin_oe_n, pull_en;
   int         num_errors = 0, n_tests = 0, k, j;
   gpmp_port #(.PINS(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .mask_ext_wr(mask_ext_wr), .mask_ext_data(mask_ext_data),
      .multi_pin_config_mask(mpcm), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_en(pull_en));
   gpmp_pad u_pad (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
      .peer_low(peer_low), .pin_in(pin_in));
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task chk(input [31:0] s, input [31:0] x);
      n_tests++;
      if (s !== x) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task xf(input w, input [11:0] a, input [7:0] dv);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, dv};
      @(posedge pclk) penable <= 1;
      n = 0;
      // Answer and data are taken at the rising edge that sees pready high
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata[7:0];
      se = pslverr;
      if (n >= 20) chk(0, 1);
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task pins;
      @(negedge pclk);
      chk(pin_oe_n, 8'(~dir));
      chk(pin_out & dir, ov & dir);
      @(posedge pclk);
   endtask
   function [7:0] nxt(input [1:0] o, input [7:0] v, input [7:0] x);
      case (o)
         0: nxt = x;
         1: nxt = v | x;
         2: nxt = v & ~x;
         default: nxt = v ^ x;
      endcase
   endfunction
   task wrap_up;
      $display("checks=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #1_000_000;
      num_errors++;
      wrap_up;
   end
   initial begin
      {presetn, psel, penable, pwrite, mask_ext_wr} = 0;
      {paddr, pwdata, mask_ext_data, peer_low, ov} = 0;
      for (k = 0; k < 8; k++) ctl[k] = 8'h00;
      void'($urandom(14745));
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (k = 0; k < 8; k++) begin
         xf(0, `GPMP_OFF_PIN0 + 4 * k, 0);
         chk(q, 0);
      end
      $display("reset test done");
      dir = 8'hff;
      xf(1, `GPMP_OFF_DIR, dir);
      // Documented sequence first, then random ops and directions
      for (k = 0; k < 44; k++) begin
         op = (k < 4) ? k : $urandom;
         d = (k < 4) ? 32'hf00ff0ff >> (24 - 8 * k) : $urandom;
         if (k % 8 == 7) begin
            dir = $urandom;
            xf(1, `GPMP_OFF_DIR, dir);
         end
         xf(1, `GPMP_OFF_OUT + 4 * op, d);
         ov = nxt(op, ov, d);
         xf(0, `GPMP_OFF_OUT, 0);
         chk(q, ov);
         pins;
      end
      $display("output test done");
      for (k = 0; k < 6; k++) begin
         m = (k == 0) ? 8'h00 : $urandom;
         e = $urandom;
         i = $urandom;
         if (m != 0) xf(1, `GPMP_OFF_MASK, m);
         xf(1, `GPMP_OFF_PIN0 + 4 * i, e);
         for (j = 0; j < 8; j++) begin
            if (m == 0 ? j == i : m[j]) ctl[j] = e;
            xf(0, `GPMP_OFF_PIN0 + 4 * j, 0);
            chk(q, ctl[j]);
         end
         xf(0, `GPMP_OFF_MASK, 0);
         chk(q, 0);
      end
      $display("multi-pin test done");
      {mask_ext_wr, mask_ext_data} <= {1'b1, 8'hff};
      @(posedge pclk) mask_ext_wr <= 0;
      @(posedge pclk);
      xf(0, `GPMP_OFF_MASK, 0);
      chk(q, 8'hff);
      xf(1, `GPMP_OFF_PIN0 + 12, 8'h38);
      xf(1, `GPMP_OFF_DIR, 8'hff);
      xf(1, `GPMP_OFF_OUT, 8'h02);
      @(negedge pclk);
      chk(pin_oe_n, 8'h02);
      chk(pin_out & ~pin_oe_n, 0);
      chk(pull_en, 8'hff);
      @(posedge pclk);
      for (k = 0; k < 2; k++) begin
         peer_low <= k ? 8'h02 : 8'h00;
         repeat (8) @(posedge pclk);
         xf(0, `GPMP_OFF_IN, 0);
         chk(q[1:0], k ? 2'b00 : 2'b10);
      end
      peer_low <= 0;
      // Plain wired-AND without pull, then pull-up on inputs
      for (k = 0; k < 2; k++) begin
         xf(1, `GPMP_OFF_DIR, k ? 8'h00 : 8'hff);
         xf(1, `GPMP_OFF_MASK, 8'hff);
         xf(1, `GPMP_OFF_PIN0, k ? 8'h18 : 8'h28);
         @(negedge pclk);
         chk(pull_en, k ? 8'hff : 8'h00);
         chk(pin_oe_n, k ? 8'hff : 8'h02);
         @(posedge pclk);
      end
      xf(1, 12'h020, 8'h5a);
      chk(se, 1'b1);
      xf(0, 12'h020, 0);
      chk({se, q}, 9'h100);
      $display("wired and unmapped test done");
      wrap_up;
   end
endmodule
